// ### rtl/ops_sampler.sv
// oversampled position sampler: n samples per sync period plus next-block timestamp
`timescale 1ns/1ps
`default_nettype none
`include "ops_sampler_cfg.svh"
module ops_sampler (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // configuration
  input  wire logic [5:0]         cfgFactor,
  input  wire logic               cfgCompact,
  input  wire logic               cfgTimestampOn,
  input  wire logic [31:0]        syncPeriodNs,
  // time base
  input  wire logic               syncPulseZero,
  input  wire logic [63:0]        localTime,
  // encoder position
  input  wire logic [63:0]        positionIn,
  // process image stream
  output logic                    outValid,
  input  wire logic               outReady,
  output ops_pkg::ops_word_s      outWord,
  // status
  output logic [5:0]              activeFactor,
  output logic                    activeCompact,
  output logic                    configError,
  output logic                    sampleOverflow,
  output logic                    sampleStrobe
);
  typedef struct packed {
    logic [5:0]         factor;
    logic               compact;
    logic               tsOn;
    logic               active;
    logic [5:0]         count;
    logic [31:0]        acc;
    logic [31:0]        period;
    logic [63:0]        blockTs;
    ops_pkg::ops_word_s pend;
    logic               pendValid;
    logic               tsPending;
    logic [63:0]        tsData;
    logic               overflow;
    logic               cfgError;
    logic               strobe;
  } ops_state_s;

  ops_state_s         s_reg;
  ops_state_s         s_next;
  logic               bufReady;
  logic               bufValid;
  ops_pkg::ops_word_s bufWord;
  logic               pushSample;
  logic               pushStamp;
  logic [31:0]        step;
  logic [31:0]        accSum;
  logic               capture;
  logic [5:0]         capIndex;
  logic               capCompact;
  logic               capTsOn;
  logic [5:0]         capFactor;

  // offered factors only, compact-only above 25, interval not below the floor
  function automatic logic cfgLegal(input logic [5:0] n, input logic cmp,
                                    input logic [31:0] per);
    logic offered;
    offered = 1'b0;
    case (n)
      6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h0A, 6'h10, 6'h14, 6'h19: offered = 1'b1;
      6'h20, 6'h28, 6'h32: offered = cmp;
      default: offered = 1'b0;
    endcase
    return offered && ({32'h0, per} >= 64'(n) * 64'(`OPS_MIN_INTERVAL_NS));
  endfunction

  assign step   = 32'(s_reg.factor) * `OPS_CLK_PERIOD_NS;
  assign accSum = s_reg.acc + step;

  always_comb begin
    s_next      = s_reg;
    pushSample  = s_reg.pendValid && bufReady;
    pushStamp   = !s_reg.pendValid && s_reg.tsPending && bufReady;
    capture     = 1'b0;
    capIndex    = s_reg.count;
    capCompact  = s_reg.compact;
    capTsOn     = s_reg.tsOn;
    capFactor   = s_reg.factor;
    s_next.strobe = 1'b0;
    if (pushSample) begin
      s_next.pendValid = 1'b0;
    end
    if (pushStamp) begin
      s_next.tsPending = 1'b0;
    end
    if (syncPulseZero) begin
      // new block: adopt a legal factor and size, else keep the running ones; period and stamp enable are always taken
      if (cfgLegal(cfgFactor, cfgCompact, syncPeriodNs)) begin
        capFactor  = cfgFactor;
        capCompact = cfgCompact;
        s_next.cfgError = 1'b0;
      end else begin
        s_next.cfgError = 1'b1;
      end
      capTsOn        = cfgTimestampOn;
      s_next.factor  = capFactor;
      s_next.compact = capCompact;
      s_next.tsOn    = capTsOn;
      s_next.period  = syncPeriodNs;
      s_next.blockTs = localTime + {32'h0, syncPeriodNs};
      s_next.acc     = 32'h0;
      s_next.active  = 1'b1;
      capture        = 1'b1;
      capIndex       = 6'h00;
    end else if (s_reg.active && (s_reg.count < s_reg.factor)) begin
      // fixed-point phase gives n equal intervals per period
      if (accSum >= s_reg.period) begin
        s_next.acc = accSum - s_reg.period;
        capture    = 1'b1;
      end else begin
        s_next.acc = accSum;
      end
    end
    if (capture) begin
      if (s_reg.pendValid && !pushSample) begin
        s_next.overflow = 1'b1;
      end
      s_next.pendValid  = 1'b1;
      s_next.strobe     = 1'b1;
      s_next.count      = capIndex + 6'h01;
      s_next.pend.kind  = ops_pkg::OPS_KIND_SAMPLE;
      s_next.pend.index = capIndex;
      s_next.pend.last  = (capIndex == capFactor - 6'h01) && !capTsOn;
      s_next.pend.data  = capCompact ? {32'h0, positionIn[`OPS_CMP_BITS-1:0]}
                                     : positionIn;
      if ((capIndex == capFactor - 6'h01) && capTsOn) begin
        if (s_reg.tsPending && !pushStamp) begin
          s_next.overflow = 1'b1;
        end
        s_next.tsPending = 1'b1;
        s_next.tsData    = syncPulseZero ? localTime + {32'h0, syncPeriodNs}
                                         : s_reg.blockTs;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg         <= '0;
      s_reg.factor  <= `OPS_RESET_FACTOR;
      s_reg.compact <= `OPS_RESET_COMPACT;
      s_reg.tsOn    <= `OPS_RESET_TS_ON;
    end else begin
      s_reg <= s_next;
    end
  end

  ops_pkg::ops_word_s inWord;
  always_comb begin
    inWord = s_reg.pend;
    if (!s_reg.pendValid) begin
      inWord.kind  = ops_pkg::OPS_KIND_STAMP;
      inWord.index = 6'h00;
      inWord.last  = 1'b1;
      inWord.data  = s_reg.tsData;
    end
  end

  ops_buffer u_buffer (
    .clk      (clk),
    .reset    (reset),
    .inValid  (s_reg.pendValid || s_reg.tsPending),
    .inReady  (bufReady),
    .inWord   (inWord),
    .outValid (bufValid),
    .outReady (outReady),
    .outWord  (bufWord)
  );

  assign outValid       = bufValid;
  assign outWord        = bufWord;
  assign activeFactor   = s_reg.factor;
  assign activeCompact  = s_reg.compact;
  assign configError    = s_reg.cfgError;
  assign sampleOverflow = s_reg.overflow;
  assign sampleStrobe   = s_reg.strobe;

  // helpers for the checks
  logic [63:0] lastStamp;
  logic        haveStamp;
  logic [5:0]  lastIndex;
  always_ff @(posedge clk) begin
    if (reset) begin
      lastStamp <= 64'h0;
      haveStamp <= 1'b0;
      lastIndex <= 6'h00;
    end else begin
      if (pushStamp) begin
        lastStamp <= s_reg.tsData;
        haveStamp <= 1'b1;
      end
      if (pushSample) begin
        lastIndex <= s_reg.pend.index;
      end
    end
  end

  a_reset_mode: assert property (@(posedge clk)
    reset |=> (activeFactor == 6'h01) && !activeCompact)
    else $error("reset mode is not factor one standard");
  a_factor_range: assert property (@(posedge clk) disable iff (reset)
    (activeFactor >= 6'h01) && (activeFactor <= 6'h32))
    else $error("factor outside 1..50");
  a_compact_only: assert property (@(posedge clk) disable iff (reset)
    (activeFactor >= 6'h20) |-> activeCompact)
    else $error("large factor without compact size");
  a_compact_width: assert property (@(posedge clk) disable iff (reset)
    pushSample && s_reg.compact |-> s_reg.pend.data[63:32] == 32'h0)
    else $error("compact sample wider than 32 bits");
  a_first_sample: assert property (@(posedge clk) disable iff (reset)
    syncPulseZero |=> sampleStrobe && s_reg.pend.index == 6'h00)
    else $error("block did not start with sample zero at sync");
  a_stamp_value: assert property (@(posedge clk) disable iff (reset)
    syncPulseZero |=> s_reg.blockTs == $past(localTime) + {32'h0, $past(syncPeriodNs)})
    else $error("timestamp is not next sync time");
  a_stamp_step: assert property (@(posedge clk) disable iff (reset)
    pushStamp && haveStamp && $stable(s_reg.period) && !s_reg.cfgError
      && s_reg.tsData != lastStamp |-> s_reg.tsData - lastStamp >= {32'h0, s_reg.period})
    else $error("timestamp stepped by less than a period");
  a_index_order: assert property (@(posedge clk) disable iff (reset)
    pushSample && s_reg.pend.index != 6'h00 |-> s_reg.pend.index == lastIndex + 6'h01)
    else $error("sample index out of order");
  a_count_bound: assert property (@(posedge clk) disable iff (reset)
    s_reg.active |-> s_reg.count <= s_reg.factor)
    else $error("more samples than factor in a block");

  c_stamp_sent: cover property (@(posedge clk) disable iff (reset) pushStamp);
  c_compact_block: cover property (@(posedge clk) disable iff (reset)
    pushSample && s_reg.compact && s_reg.pend.index == 6'h03);
  c_stall: cover property (@(posedge clk) disable iff (reset)
    outValid && !outReady ##1 outValid && !outReady);
  c_bad_cfg: cover property (@(posedge clk) disable iff (reset) $rose(configError));
endmodule
`default_nettype wire

// ### rtl/ops_sampler_cfg.svh
// constants of the oversampled position sampler
`ifndef OPS_SAMPLER_CFG_SVH
`define OPS_SAMPLER_CFG_SVH
`define OPS_CLK_PERIOD_NS   32'd10
`define OPS_RESET_FACTOR    6'h01
`define OPS_RESET_COMPACT   1'b0
`define OPS_RESET_TS_ON     1'b1
`define OPS_MAX_FACTOR      6'h32
`define OPS_COMPACT_MIN     6'h20
`define OPS_MIN_INTERVAL_NS 32'd25000
`define OPS_STD_BITS        64
`define OPS_CMP_BITS        32
`endif

// ### rtl/ops_pkg.sv
// types of the oversampled position sampler
`default_nettype none
package ops_pkg;
  typedef enum logic {OPS_KIND_SAMPLE, OPS_KIND_STAMP} ops_kind_e;
  typedef struct packed {
    ops_kind_e   kind;
    logic [5:0]  index;
    logic        last;
    logic [63:0] data;
  } ops_word_s;
endpackage
`default_nettype wire

// ### rtl/ops_buffer.sv
// two-entry buffer for process image words
`timescale 1ns/1ps
`default_nettype none
module ops_buffer (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // fill side
  input  wire logic              inValid,
  output logic                   inReady,
  input  wire ops_pkg::ops_word_s inWord,
  // drain side
  output logic                   outValid,
  input  wire logic              outReady,
  output ops_pkg::ops_word_s     outWord
);
  typedef struct packed {
    ops_pkg::ops_word_s [1:0] mem;
    logic                     wrPtr;
    logic                     rdPtr;
    logic [1:0]               count;
  } ops_buf_s;

  ops_buf_s s_reg;
  ops_buf_s s_next;
  logic     doPush;
  logic     doPop;

  assign inReady  = (s_reg.count != 2'h2);
  assign outValid = (s_reg.count != 2'h0);
  assign outWord  = s_reg.mem[s_reg.rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb begin
    s_next = s_reg;
    if (doPush) begin
      s_next.mem[s_reg.wrPtr] = inWord;
      s_next.wrPtr = ~s_reg.wrPtr;
    end
    if (doPop) begin
      s_next.rdPtr = ~s_reg.rdPtr;
    end
    s_next.count = s_reg.count + {1'b0, doPush} - {1'b0, doPop};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  a_buf_count: assert property (@(posedge clk) disable iff (reset)
    s_reg.count <= 2'h2)
    else $error("buffer count out of range");
endmodule
`default_nettype wire

// ### tb/ops_host_model.sv
// far-side process image reader model
`timescale 1ns/1ps
`default_nettype none
module ops_host_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // stall control
  input  wire logic               stall,
  input  wire logic               slow,
  // process image stream
  input  wire logic               outValid,
  output logic                    outReady,
  input  wire ops_pkg::ops_word_s outWord
);
  ops_pkg::ops_word_s got[$];
  logic               tick = 1'b0;
  initial outReady = 1'b0;
  // ready pattern, changed off the sampling edge
  always @(negedge clk) begin
    tick     <= ~tick;
    outReady <= ~stall & (~slow | tick);
  end
  // image holds the n samples and the stamp as offered
  always @(posedge clk) begin
    if (!reset && outValid && outReady) begin
      got.push_back(outWord);
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench of the oversampled position sampler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic               clk = 1'b0, reset = 1'b1, cfgCompact = 1'b0, cfgTimestampOn = 1'b1;
  logic               syncPulseZero = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [5:0]         cfgFactor = 6'h01;
  logic [31:0]        syncPeriodNs = 32'h0000C350;
  logic [63:0]        localTime = 64'hFFFFFFFE00000000;
  logic [63:0]        startT, prevStamp, d;
  logic               outValid, outReady, activeCompact, configError, sampleOverflow, sampleStrobe;
  logic [5:0]         activeFactor;
  ops_pkg::ops_word_s outWord;
  int                 error_cnt = 0;
  int                 n_tests = 0;
  logic [5:0]         fac[12] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h0A,
                                  6'h10, 6'h14, 6'h19, 6'h20, 6'h28, 6'h32};
  logic [5:0]         badN[4] = '{6'h20, 6'h14, 6'h03, 6'h04};
  logic [31:0]        badP[4] = '{32'h000C3500, 32'h00061A80, 32'h000186A0, 32'h00018696};
  ops_sampler u_dut (.clk(clk), .reset(reset), .cfgFactor(cfgFactor), .cfgCompact(cfgCompact),
    .cfgTimestampOn(cfgTimestampOn), .syncPeriodNs(syncPeriodNs), .syncPulseZero(syncPulseZero),
    .localTime(localTime), .positionIn(localTime), .outValid(outValid), .outReady(outReady),
    .outWord(outWord), .activeFactor(activeFactor), .activeCompact(activeCompact),
    .configError(configError), .sampleOverflow(sampleOverflow), .sampleStrobe(sampleStrobe));
  ops_host_model u_host (.clk(clk), .reset(reset), .stall(stall), .slow(slow),
    .outValid(outValid), .outReady(outReady), .outWord(outWord));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(negedge clk) localTime <= localTime + 64'h000000000000000A;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic sync(input logic [5:0] n, input logic c, input logic [31:0] p);
    cfgFactor = n;
    cfgCompact = c;
    syncPeriodNs = p;
    syncPulseZero = 1'b1;
    @(posedge clk) startT = localTime;
    @(negedge clk);
    syncPulseZero = 1'b0;
  endtask
  // one full sync period, then the words of the block are checked
  task automatic block(input logic [5:0] n, input logic c, input logic [31:0] p, input logic inc);
    int k;
    u_host.got.delete();
    sync(n, c, p);
    repeat (p / 10 - 1) @(negedge clk);
    `CHK(u_host.got.size(), n + cfgTimestampOn)
    for (k = 0; k < n && k < u_host.got.size(); k++) begin
      `CHK(u_host.got[k].kind, ops_pkg::OPS_KIND_SAMPLE)
      `CHK(u_host.got[k].index, 6'(k))
      `CHK(u_host.got[k].last, k == n - 1 && !cfgTimestampOn)
      d = u_host.got[k].data - (startT + k * (p / n));
      if (c) begin
        `CHK(u_host.got[k].data[63:32], 32'h00000000)
        d = {{32{d[31]}}, d[31:0]};
      end
      `CHK(d + 64'h000000000000000A <= 64'h0000000000000014, 1'b1)
    end
    if (cfgTimestampOn && u_host.got.size() > n) begin
      `CHK(u_host.got[n].kind, ops_pkg::OPS_KIND_STAMP)
      `CHK(u_host.got[n].data, startT + p)
      if (inc) `CHK(u_host.got[n].data - prevStamp, {32'h00000000, p})
      prevStamp = u_host.got[n].data;
    end
  endtask
  initial begin
    #1000000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    `CHK(activeFactor, 6'h01)
    `CHK(activeCompact, 1'b0)
    `CHK(outValid, 1'b0)
    block(6'h01, 1'b0, 32'h0000C350, 1'b0);
    block(6'h01, 1'b0, 32'h0000C350, 1'b1);
    slow = 1'b1;
    block(6'h04, 1'b1, 32'h000186A0, 1'b0);
    cfgTimestampOn = 1'b0;
    block(6'h02, 1'b0, 32'h0000C350, 1'b0);
    cfgTimestampOn = 1'b1;
    slow = 1'b0;
    foreach (fac[i]) begin
      sync(fac[i], fac[i] >= 6'h20, 32'(fac[i]) * 32'h000061A8);
      `CHK(activeFactor, fac[i])
      `CHK(configError, 1'b0)
      `CHK(sampleStrobe, 1'b1)
      @(negedge clk);
    end
    foreach (badN[i]) begin
      sync(badN[i], 1'b0, badP[i]);
      `CHK(configError, 1'b1)
      `CHK(activeFactor, 6'h32)
      @(negedge clk);
    end
    stall = 1'b1;
    sync(6'h04, 1'b1, 32'h000186A0);
    repeat (10000) @(negedge clk);
    `CHK(sampleOverflow, 1'b1)
    stall = 1'b0;
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    `CHK(sampleOverflow, 1'b0)
    `CHK(activeFactor, 6'h01)
    `CHK(configError, 1'b0)
    end_sim();
  end
endmodule
`default_nettype wire
